// ---- adc_irq_pkg.sv ----
// shared constants and types for the converter sequencer and interrupt block
package adc_irq_pkg;
    // clock and timing
    localparam int CLK_MHZ = 200;
    localparam int T_PHASE_US = 2000; // warm-up and integration phase, about 2 ms
    localparam int RES_STEPS = 256; // 8-bit result resolution
    localparam int STEP_CYC_DEF = (T_PHASE_US * CLK_MHZ) / RES_STEPS; // rounded down
    localparam int WARM_STEPS = RES_STEPS;
    localparam int INT_STEPS = RES_STEPS;
    // register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h0B;
    localparam logic [7:0] ADDR_DATA = 8'h0C;
    localparam logic [7:0] ADDR_MASK = 8'h0D;
    localparam logic [7:0] ADDR_FLAGS = 8'h0E;
    // converter_control fields
    localparam int CTRL_OVF_BIT = 5;
    localparam int CTRL_READY_BIT = 4;
    localparam int CTRL_START_BIT = 3;
    localparam int CTRL_EN_BIT = 2;
    localparam int CTRL_SEL_LSB = 0;
    // interrupt_request_flags fields
    localparam int FLG_UV_BIT = 7;
    localparam int FLG_UCMD_BIT = 6;
    localparam int FLG_PERR_BIT = 5;
    localparam int FLG_DONE_BIT = 4;
    localparam int FLG_COMP_LSB = 0;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] FLAGS_RST = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WARM = 2'b01,
        ST_INTEG = 2'b10,
        ST_DEINT = 2'b11
    } conv_state_t;

    // one register access, taken in the cycle wr or rd is high
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // analog front-end controls
    typedef struct packed {
        logic integrate;
        logic deintegrate;
        logic [1:0] mux_sel;
        logic path_en;
        logic ref_en;
    } analog_ctl_t;
endpackage

// ---- step_tick.sv ----
// step enable generator for the conversion timebase
`timescale 1ns/1ps
`default_nettype none
module step_tick import adc_irq_pkg::*; #(
    parameter int STEP_CYCLES = STEP_CYC_DEF
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // control and pulse
    input wire logic run,
    output logic tick
);
    logic [15:0] cnt_q;

    // free count while running, restart when idle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 16'h0000;
        end else if (!run || cnt_q == 16'(STEP_CYCLES - 1)) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    assign tick = run && (cnt_q == 16'(STEP_CYCLES - 1));

    property p_tick_spacing;
        @(posedge mclk) disable iff (!rst_n)
        tick |=> !tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("step tick too close");
endmodule // step_tick
`default_nettype wire

// ---- irq_flags.sv ----
// sticky interrupt flags, mask gating and open-drain request pin
`timescale 1ns/1ps
`default_nettype none
module irq_flags import adc_irq_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // events and software access
    input wire logic [7:0] set_evt,
    input wire logic [7:0] clr_w1c,
    input wire logic [7:0] mask,
    output logic [7:0] flags_q,
    // request pin
    output logic irq_n_out,
    output logic irq_n_oe
);
    logic [7:0] flags_d;

    // a set in the clearing cycle wins; all flags held side by side
    always_comb begin
        flags_d = (flags_q & ~clr_w1c) | set_evt;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // pull low while any unmasked flag pends, else release
    assign irq_n_out = 1'b0;
    assign irq_n_oe = |(flags_q & ~mask);

    property p_w1c;
        @(posedge mclk) disable iff (!rst_n)
        (clr_w1c[FLG_DONE_BIT] && !set_evt[FLG_DONE_BIT]) |=> !flags_q[FLG_DONE_BIT];
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared by one");

    property p_set_kept;
        @(posedge mclk) disable iff (!rst_n)
        set_evt[FLG_DONE_BIT] |=> flags_q[FLG_DONE_BIT]
            ##1 (flags_q[FLG_DONE_BIT] || $past(clr_w1c[FLG_DONE_BIT]));
    endproperty
    a_set_kept: assert property (p_set_kept) else $error("event flag lost");

    property p_pin;
        @(posedge mclk) disable iff (!rst_n)
        $rose(flags_q[FLG_UV_BIT]) && !mask[FLG_UV_BIT] |-> irq_n_oe;
    endproperty
    a_pin: assert property (p_pin) else $error("request pin not driven");

    c_irq: cover property (@(posedge mclk) disable iff (!rst_n) $fell(irq_n_oe));
endmodule // irq_flags
`default_nettype wire

// ---- adc_sequencer.sv ----
// converter sequencer with register file and interrupt request
// Overview of operation
// - result is an 8-bit dual-slope code over reference to twice reference
// - first enable adds an extra warm-up of about 2 ms
// - fixed 2 ms input integration then 0 to 2 ms reference de-integration
// - one of four pins reaches the converter through the input multiplexer
// - converter disabled after reset; enable bit turns it on and off
// - writing one to a cleared start bit while enabled begins a conversion
// - result-ready bit set on completion, 2 to 4 ms after start, 4 to 6 ms with the warm-up
// - conversion-done flag raised together with result-ready
// - reference on while enable pin high and no shutdown executed
// - request pin pulled low while any unmasked flag pends
// - flags: 7 undervoltage, 6 undefined command, 5 parity, 4 done, 3:0 comparators
// - comparator flag only for a pin set as comparator, on a trip
// - mask blocks the pin but the flag is still latched
// - writing one clears a flag; writing zero leaves it
// - no hardware priority; all pending flags visible together
// - two-bit select field, values 0 to 3 pick the pin
// - converter path active unless the pin is a general purpose output
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer import adc_irq_pkg::*; #(
    parameter int STEP_CYCLES = STEP_CYC_DEF
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register access
    input wire reg_req_t req,
    output logic [7:0] rdata_q,
    // device state
    input wire logic en_pin,
    input wire logic shutdown_active,
    // multi-function pin configuration and comparator trips
    input wire logic [3:0] gpo_enable,
    input wire logic [3:0] comp_enable,
    input wire logic [3:0] comp_trip,
    // other event sources, one-cycle pulses
    input wire logic uv_event,
    input wire logic undef_cmd_event,
    input wire logic parity_err_event,
    // analog front end
    input wire logic integ_zero,
    output analog_ctl_t ana_q,
    // request pin, open drain
    output logic irq_n_out,
    output logic irq_n_oe
);
    // true when the given pin works as general purpose output
    function automatic logic pin_is_gpo(input logic [3:0] gpo, input logic [1:0] sel);
        pin_is_gpo = gpo[sel];
    endfunction

    conv_state_t state_q, state_d;
    logic [1:0] sel_q;
    logic en_q, start_q, ready_q, ovf_q, warm_done_q;
    logic [7:0] data_q, mask_q;
    logic [8:0] cnt_q;
    logic tick, wr_ctrl, start_trig, conv_done, conv_ovf, ref_on, en_now;
    logic [7:0] flags_q, set_evt, clr_w1c;

    assign wr_ctrl = req.wr && (req.addr == ADDR_CTRL);
    // launch only on a written zero-to-one of the start bit while enabled
    assign start_trig = wr_ctrl && req.wdata[CTRL_START_BIT] && !start_q
                        && req.wdata[CTRL_EN_BIT];
    assign ref_on = en_pin && !shutdown_active;
    // enable as it stands after a write in this cycle, so enable plus start launches
    assign en_now = wr_ctrl ? req.wdata[CTRL_EN_BIT] : en_q;

    // timebase: one step is 1/256 of a 2 ms phase
    step_tick #(.STEP_CYCLES(STEP_CYCLES)) u_tick (
        .mclk(mclk),
        .rst_n(rst_n),
        .run(state_q != ST_IDLE),
        .tick(tick)
    );

    // converter control register fields
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= CTRL_RST[CTRL_SEL_LSB +: 2];
            en_q <= CTRL_RST[CTRL_EN_BIT];
            start_q <= CTRL_RST[CTRL_START_BIT];
        end else if (wr_ctrl) begin
            sel_q <= req.wdata[CTRL_SEL_LSB +: 2];
            en_q <= req.wdata[CTRL_EN_BIT];
            start_q <= req.wdata[CTRL_START_BIT];
        end
    end

    // interrupt mask register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= MASK_RST;
        end else if (req.wr && req.addr == ADDR_MASK) begin
            mask_q <= req.wdata;
        end
    end

    // completion: reference crossing or full-scale overflow
    assign conv_ovf = (state_q == ST_DEINT) && tick && (cnt_q == 9'(RES_STEPS - 1));
    assign conv_done = (state_q == ST_DEINT) && (integ_zero || conv_ovf);

    // conversion phase sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start_trig) begin
                    state_d = warm_done_q ? ST_INTEG : ST_WARM;
                end
            end
            ST_WARM: begin
                if (tick && cnt_q == 9'(WARM_STEPS - 1)) begin
                    state_d = ST_INTEG;
                end
            end
            ST_INTEG: begin
                if (tick && cnt_q == 9'(INT_STEPS - 1)) begin
                    state_d = ST_DEINT;
                end
            end
            ST_DEINT: begin
                if (conv_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // disable or loss of reference abandons a conversion
        if (!en_now || !ref_on) begin
            state_d = ST_IDLE;
        end
    end

    // state register and step counter
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 9'h000;
        end else begin
            state_q <= state_d;
            if (state_d != state_q) begin
                cnt_q <= 9'h000;
            end else if (tick) begin
                cnt_q <= cnt_q + 9'h001;
            end
        end
    end

    // warm-up is needed only for the first activation
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            warm_done_q <= 1'b0;
        end else if (state_q == ST_WARM && state_d == ST_INTEG) begin
            warm_done_q <= 1'b1;
        end
    end

    // result, ready and overflow capture
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= DATA_RST;
            ready_q <= CTRL_RST[CTRL_READY_BIT];
            ovf_q <= CTRL_RST[CTRL_OVF_BIT];
        end else if (conv_done) begin
            data_q <= conv_ovf ? 8'hFF : cnt_q[7:0];
            ready_q <= 1'b1;
            ovf_q <= conv_ovf;
        end else if (start_trig && state_q == ST_IDLE) begin
            ready_q <= 1'b0;
            ovf_q <= 1'b0;
        end
    end

    // analog controls, registered
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ana_q <= '0;
        end else begin
            ana_q.integrate <= (state_d == ST_INTEG);
            ana_q.deintegrate <= (state_d == ST_DEINT);
            ana_q.mux_sel <= sel_q;
            ana_q.path_en <= !pin_is_gpo(gpo_enable, sel_q);
            ana_q.ref_en <= ref_on;
        end
    end

    // event sources into flag positions
    always_comb begin
        set_evt = 8'h00;
        set_evt[FLG_UV_BIT] = uv_event;
        set_evt[FLG_UCMD_BIT] = undef_cmd_event;
        set_evt[FLG_PERR_BIT] = parity_err_event;
        set_evt[FLG_DONE_BIT] = conv_done;
        set_evt[FLG_COMP_LSB +: 4] = comp_trip & comp_enable & ~gpo_enable;
        clr_w1c = (req.wr && req.addr == ADDR_FLAGS) ? req.wdata : 8'h00;
    end

    irq_flags u_irq (
        .mclk(mclk),
        .rst_n(rst_n),
        .set_evt(set_evt),
        .clr_w1c(clr_w1c),
        .mask(mask_q),
        .flags_q(flags_q),
        .irq_n_out(irq_n_out),
        .irq_n_oe(irq_n_oe)
    );

    // registered read data, unmapped offsets read zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                ADDR_CTRL: rdata_q <= {2'b00, ovf_q, ready_q, start_q, en_q, sel_q};
                ADDR_DATA: rdata_q <= data_q;
                ADDR_MASK: rdata_q <= mask_q;
                ADDR_FLAGS: rdata_q <= flags_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    property p_disabled_idle;
        @(posedge mclk) disable iff (!rst_n)
        !en_q && !start_trig |=> state_q == ST_IDLE;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle)
        else $error("busy while disabled");

    property p_launch;
        @(posedge mclk) disable iff (!rst_n)
        start_trig && state_q == ST_IDLE && ref_on |=> state_q inside {ST_WARM, ST_INTEG};
    endproperty
    a_launch: assert property (p_launch) else $error("start not taken");

    property p_no_relaunch;
        @(posedge mclk) disable iff (!rst_n)
        wr_ctrl && start_q && state_q == ST_IDLE |=> state_q == ST_IDLE;
    endproperty
    a_no_relaunch: assert property (p_no_relaunch)
        else $error("launched without 0-1");

    property p_warm_once;
        @(posedge mclk) disable iff (!rst_n)
        start_trig && state_q == ST_IDLE && warm_done_q && ref_on |=> state_q == ST_INTEG;
    endproperty
    a_warm_once: assert property (p_warm_once) else $error("warm-up repeated");

    property p_done_ready;
        @(posedge mclk) disable iff (!rst_n)
        conv_done |=> ready_q && flags_q[FLG_DONE_BIT]
            && data_q == $past(conv_ovf ? 8'hFF : cnt_q[7:0]);
    endproperty
    a_done_ready: assert property (p_done_ready)
        else $error("done not reported");

    property p_ref;
        @(posedge mclk) disable iff (!rst_n)
        !en_pin |=> !ana_q.ref_en && state_q == ST_IDLE;
    endproperty
    a_ref: assert property (p_ref) else $error("reference on with pin low");

    property p_path;
        @(posedge mclk) disable iff (!rst_n)
        gpo_enable[sel_q] |=> !ana_q.path_en;
    endproperty
    a_path: assert property (p_path) else $error("path open on output pin");

    property p_mux_sel;
        @(posedge mclk) disable iff (!rst_n)
        wr_ctrl |=> sel_q == $past(req.wdata[CTRL_SEL_LSB +: 2])
            ##1 ana_q.mux_sel == $past(sel_q);
    endproperty
    a_mux_sel: assert property (p_mux_sel)
        else $error("input select not applied");

    property p_comp_only;
        @(posedge mclk) disable iff (!rst_n)
        (comp_trip & comp_enable & ~gpo_enable) == 4'h0
            |=> (flags_q[FLG_COMP_LSB +: 4] & ~$past(flags_q[FLG_COMP_LSB +: 4])) == 4'h0;
    endproperty
    a_comp_only: assert property (p_comp_only)
        else $error("stray comparator flag");

    property p_ready_clear;
        @(posedge mclk) disable iff (!rst_n)
        start_trig && state_q == ST_IDLE |=> !ready_q;
    endproperty
    a_ready_clear: assert property (p_ready_clear)
        else $error("ready kept over a new start");

    property p_overflow;
        @(posedge mclk) disable iff (!rst_n)
        conv_ovf |=> data_q == 8'hFF && ready_q;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow not saturated");

    property p_release;
        @(posedge mclk) disable iff (!rst_n)
        (flags_q & ~mask_q) == 8'h00 |-> !irq_n_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("request pin held with nothing pending");

    c_full_conv: cover property (@(posedge mclk) disable iff (!rst_n) conv_done && !conv_ovf);
    c_overflow: cover property (@(posedge mclk) disable iff (!rst_n) conv_ovf);
    c_warm: cover property (@(posedge mclk) disable iff (!rst_n) state_q == ST_WARM ##1 state_q == ST_INTEG);
endmodule // adc_sequencer
`default_nettype wire

// ---- analog_model.sv ----
// behavioural integrator and zero-cross comparator facing the converter
`timescale 1ns/1ps
`default_nettype none
module analog_model import adc_irq_pkg::*; #(
    parameter int STEP = 4
) (
    // clock and front-end controls
    input wire logic mclk,
    input wire analog_ctl_t ana,
    input var int level,
    // comparator output
    output logic integ_zero
);
    int cnt = 0;
    logic tog = 1'b0;
    // count de-integration cycles; zero is crossed after level steps
    always @(posedge mclk) begin
        tog <= ~tog;
        cnt <= ana.deintegrate ? cnt + 1 : 0;
    end
    // outside de-integration the comparator output wanders
    assign integ_zero = ana.deintegrate ? (cnt >= level * STEP) : tog;
endmodule // analog_model
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the converter sequencer and interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_top import adc_irq_pkg::*;;
    localparam int S = 4;
    logic mclk, rst_n, en_pin, shutdown_active, uv, ucmd, perr, integ_zero;
    logic irq_n_out, irq_n_oe;
    logic [7:0] rd_q;
    logic [3:0] gpo, cmpen, trip;
    logic [7:0] rd_v, t;
    logic [7:0] ra [5] = '{ADDR_CTRL, ADDR_DATA, ADDR_MASK, ADDR_FLAGS, 8'h3F};
    reg_req_t req;
    analog_ctl_t ana_q;
    int failures = 0, n_compared = 0, level = 0, flg_m = 0, msk_m = 0, cyc, sel, ex;

    adc_sequencer #(.STEP_CYCLES(S)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .req(req), .rdata_q(rd_q),
        .en_pin(en_pin), .shutdown_active(shutdown_active),
        .gpo_enable(gpo), .comp_enable(cmpen), .comp_trip(trip),
        .uv_event(uv), .undef_cmd_event(ucmd), .parity_err_event(perr),
        .integ_zero(integ_zero), .ana_q(ana_q),
        .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe)
    );
    analog_model #(.STEP(S)) u_ana (
        .mclk(mclk), .ana(ana_q), .level(level), .integ_zero(integ_zero)
    );

    // clock generation
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge mclk);
        req.wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge mclk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge mclk);
        req.rd = 1'b0;
        rd_v = rd_q;
    endtask

    task automatic chk_flags();
        rd(ADDR_FLAGS);
        chk("flags", rd_v, flg_m[7:0]);
        chk("irq_oe", irq_n_oe, |(flg_m[7:0] & ~msk_m[7:0]));
    endtask

    task automatic pulse(input logic [2:0] e, input logic [3:0] tr);
        @(negedge mclk);
        {uv, ucmd, perr} = e;
        trip = tr;
        @(negedge mclk);
        {uv, ucmd, perr} = 3'b000;
        trip = 4'h0;
    endtask

    // one conversion through the model, then result, timing and flag checks
    task automatic conv(input int lvl, input int warm);
        level = lvl;
        sel = $urandom_range(3);
        ex = (warm * 256 + 256 + (lvl > 255 ? 256 : lvl)) * S;
        wr(ADDR_CTRL, 8'h04 | sel[7:0]);
        wr(ADDR_CTRL, 8'h0C | sel[7:0]);
        chk("mux", ana_q.mux_sel, sel[1:0]);
        chk("path", ana_q.path_en, !gpo[sel]);
        chk("integrate", ana_q.integrate, warm == 0);
        cyc = 1;
        while (!irq_n_oe && cyc < 4000) begin
            @(negedge mclk);
            cyc++;
        end
        cyc -= ex;
        chk("conv_time", cyc > -3 * S && cyc < 3 * S, 1'b1);
        flg_m |= 8'h10;
        rd(ADDR_DATA);
        chk("data", rd_v, lvl > 255 ? 8'hFF : lvl[7:0]);
        rd(ADDR_CTRL);
        chk("ctrl", rd_v, (lvl > 255 ? 8'h3C : 8'h1C) | sel[7:0]);
        chk_flags();
        wr(ADDR_FLAGS, 8'h10);
        flg_m &= ~8'h10;
        chk_flags();
    endtask

    task automatic results();
        if (failures == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge mclk);
        failures++;
        results();
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        req = '0;
        {en_pin, shutdown_active, uv, ucmd, perr} = 5'b10000;
        {gpo, cmpen, trip} = 12'h000;
        void'($urandom(47352));
        repeat (16) @(posedge mclk);
        @(negedge mclk) rst_n = 1'b1;
        wr(ADDR_DATA, 8'hA5);
        wr(8'h3F, 8'hFF);
        foreach (ra[i]) begin
            rd(ra[i]);
            chk("reset_read", rd_v, 8'h00);
        end
        chk("irq_out", irq_n_out, 1'b0);
        chk("irq_oe_rst", irq_n_oe, 1'b0);
        for (int i = 0; i < 8; i++) begin
            // converter enable is still clear while shutdown toggles
            @(negedge mclk) {en_pin, shutdown_active} = 2'($urandom_range(3));
            @(negedge mclk) chk("ref_en", ana_q.ref_en, en_pin && !shutdown_active);
        end
        {en_pin, shutdown_active} = 2'b10;
        conv($urandom_range(1, 200), 1);
        // start bit already one: no relaunch
        wr(ADDR_CTRL, 8'h0C | sel[7:0]);
        repeat (3) @(negedge mclk);
        chk("no_relaunch", ana_q.integrate, 1'b0);
        gpo = 4'($urandom_range(15));
        conv($urandom_range(0, 255), 0);
        // disabling in mid-conversion aborts without a result
        wr(ADDR_CTRL, 8'h04);
        wr(ADDR_CTRL, 8'h0C);
        repeat (20) @(negedge mclk);
        wr(ADDR_CTRL, 8'h00);
        repeat (300) @(negedge mclk);
        chk("abort", ana_q.integrate | ana_q.deintegrate, 1'b0);
        chk_flags();
        conv(1000, 0);
        // masking, write-zero and partial clears
        msk_m = 8'h20;
        wr(ADDR_MASK, 8'h20);
        rd(ADDR_MASK);
        chk("mask", rd_v, 8'h20);
        pulse(3'b111, 4'h0);
        flg_m |= 8'hE0;
        chk_flags();
        wr(ADDR_FLAGS, 8'h00);
        chk_flags();
        wr(ADDR_FLAGS, 8'hC0);
        flg_m &= ~8'hC0;
        chk_flags();
        msk_m = 0;
        wr(ADDR_MASK, 8'h00);
        chk_flags();
        // comparator trips only on comparator pins that are not outputs
        cmpen = 4'b0111;
        gpo = 4'b0010;
        t = 8'($urandom_range(15)) | 8'h01;
        pulse(3'b000, t[3:0]);
        flg_m |= t & {4'h0, cmpen & ~gpo};
        chk_flags();
        wr(ADDR_FLAGS, 8'hFF);
        flg_m = 0;
        chk_flags();
        results();
    end
endmodule // tb_top
`default_nettype wire
